//--- shared/apbi_pkg.sv
// Constants and types for the asynchronous processor bus interface
// ==========================================================================
// Summary of operation
// - Drive 24-bit three-state request address for every cycle except interrupt acknowledge.
// - Interrupt acknowledge places serviced level on address lines three to one.
// - Interrupt acknowledge drives address lines 23..4 and line 0 high.
// - Sixteen-line bidirectional data bus; static input selects 8- or 16-bit mode.
// - Address strobe asserted only while a valid address is driven.
// - Read/write select marks each transfer as read or write.
// - Separate upper and lower byte strobes select active data halves.
// - Interrupt requests accepted at seven priority levels.
// - Low-power mode keeps all internal state for lossless resume.
// - Fully static logic; stopping the clock corrupts nothing.
// - Three encoded priority inputs; level seven non-maskable; auto-vector input.
// - Three access-space code outputs, valid whenever address strobe is asserted.
// - Bus request answered by bus grant; bus released after current cycle.
package apbi_pkg;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int LVL_W  = 3;
  localparam int FC_W   = 3;
  localparam logic [2:0] LVL_NMI = 3'h7;
  localparam logic [2:0] FC_IACK = 3'h7;
  localparam logic [ADDR_W-1:0] IACK_ADDR_BASE = 24'hffffff;
  localparam int DEPTH = 2;

  typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_IACK} apbi_op_t;
  typedef enum {ST_IDLE, ST_ADDR, ST_WAIT, ST_DONE, ST_GRANT} apbi_state_t;
endpackage

//--- hw/apbi_buf.sv
// Two-entry valid/ready buffer for completed read data
`timescale 1ns/1ps
module apbi_buf
#(
  parameter int W = 16
)
(
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic         i_valid,
  output logic              o_ready,
  input  wire logic [W-1:0] i_data,
  output logic              o_valid,
  input  wire logic         i_ready,
  output logic [W-1:0]      o_data
);
  logic [W-1:0] mem_q [apbi_pkg::DEPTH];
  logic         wp_q;
  logic         rp_q;
  logic [1:0]   cnt_q;
  logic         push;
  logic         pop;

  assign o_ready = (cnt_q != 2'h2);
  assign o_valid = (cnt_q != 2'h0);
  assign o_data  = mem_q[rp_q];
  assign push    = i_valid && o_ready;
  assign pop     = o_valid && i_ready;

  always_ff @(posedge i_clk)
  begin
    if (push)
      mem_q[wp_q] <= i_data;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      wp_q  <= 1'b0;
      rp_q  <= 1'b0;
      cnt_q <= 2'h0;
    end
    else
    begin
      if (push)
        wp_q <= ~wp_q;
      if (pop)
        rp_q <= ~rp_q;
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule // apbi_buf

//--- hw/apbi_core.sv
// Bus master sequencer of the asynchronous processor bus interface
`timescale 1ns/1ps
module apbi_core
(
  input  wire logic                          i_clk,
  input  wire logic                          i_rst,
  // Core request side
  input  wire logic                          i_req_valid,
  output logic                               o_req_ready,
  input  wire apbi_pkg::apbi_op_t            i_req_op,
  input  wire logic [apbi_pkg::ADDR_W-1:0]   i_req_addr,
  input  wire logic [apbi_pkg::DATA_W-1:0]   i_req_wdata,
  input  wire logic                          i_req_word,
  input  wire logic [apbi_pkg::FC_W-1:0]     i_req_space,
  input  wire logic [apbi_pkg::LVL_W-1:0]    i_iack_level,
  output logic                               o_rd_valid,
  input  wire logic                          i_rd_ready,
  output logic [apbi_pkg::DATA_W-1:0]        o_rd_data,
  output logic                               o_iack_auto,
  // Interrupt side
  input  wire logic [apbi_pkg::LVL_W-1:0]    i_interrupt_priority_inputs_n,
  input  wire logic [apbi_pkg::LVL_W-1:0]    i_int_mask,
  output logic [apbi_pkg::LVL_W-1:0]         o_int_pending,
  // Static width select: 1 = 8-bit mode
  input  wire logic                          i_mode_8bit,
  // Bus pins
  output logic [apbi_pkg::ADDR_W-1:0]        o_address_lines,
  output logic                               o_address_oe,
  input  wire logic [apbi_pkg::DATA_W-1:0]   i_data_lines,
  output logic [apbi_pkg::DATA_W-1:0]        o_data_lines,
  output logic                               o_data_oe,
  output logic                               o_address_strobe_n,
  output logic                               o_read_write,
  output logic                               o_upper_byte_strobe_n,
  output logic                               o_lower_byte_strobe_n,
  output logic [apbi_pkg::FC_W-1:0]          o_access_space_code,
  output logic                               o_ctrl_oe,
  input  wire logic                          i_transfer_ack_n,
  input  wire logic                          i_auto_vector_request_n,
  input  wire logic                          i_bus_request_n,
  output logic                               o_bus_grant_n
);
  apbi_pkg::apbi_state_t             state_q;
  apbi_pkg::apbi_op_t                op_q;
  logic [apbi_pkg::ADDR_W-1:0]       addr_q;
  logic [apbi_pkg::DATA_W-1:0]       wdata_q;
  logic [apbi_pkg::DATA_W-1:0]       rdata_q;
  logic                              word_q;
  logic [apbi_pkg::FC_W-1:0]         space_q;
  logic                              rd_push_q;
  logic                              auto_q;
  logic [apbi_pkg::LVL_W-1:0]        lvl_q;
  logic                              buf_ready;
  logic                              start;
  logic [apbi_pkg::LVL_W-1:0]        req_lvl;
  logic                              bus_off;
  logic                              cycle_end;

  // ==========================================================================
  // Helpers
  function automatic logic [apbi_pkg::ADDR_W-1:0] iack_addr(input logic [2:0] lvl);
    iack_addr = {apbi_pkg::IACK_ADDR_BASE[23:4], lvl, 1'b1};
  endfunction

  assign req_lvl       = ~i_interrupt_priority_inputs_n;
  // Level seven ignores the mask; lower levels must exceed it
  assign o_int_pending = ((req_lvl == apbi_pkg::LVL_NMI) || (req_lvl > i_int_mask)) ? req_lvl : 3'h0;

  // Requests held while the bus is granted or busy
  assign start       = (state_q == apbi_pkg::ST_IDLE) && i_bus_request_n && i_req_valid;
  assign o_req_ready = (state_q == apbi_pkg::ST_IDLE) && i_bus_request_n;

  // Bus handed over, or about to be
  assign bus_off   = (state_q == apbi_pkg::ST_GRANT) ||
                     (state_q == apbi_pkg::ST_IDLE && !i_bus_request_n);
  // Acknowledge ends the cycle; a read also needs room for its data
  assign cycle_end = (state_q == apbi_pkg::ST_WAIT) && !i_transfer_ack_n &&
                     (op_q == apbi_pkg::OP_WRITE || buf_ready);

  // ==========================================================================
  // Bus cycle sequencer; all state in flip-flops, static under stopped clock
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      state_q <= apbi_pkg::ST_IDLE;
    else
    begin
      unique case (state_q)
        apbi_pkg::ST_IDLE:
          if (!i_bus_request_n)
            state_q <= apbi_pkg::ST_GRANT;
          else if (i_req_valid)
            state_q <= apbi_pkg::ST_ADDR;
        apbi_pkg::ST_ADDR:
          state_q <= apbi_pkg::ST_WAIT;
        apbi_pkg::ST_WAIT:
          if (cycle_end)
            state_q <= apbi_pkg::ST_DONE;
        apbi_pkg::ST_DONE:
          state_q <= apbi_pkg::ST_IDLE;
        apbi_pkg::ST_GRANT:
          if (i_bus_request_n)
            state_q <= apbi_pkg::ST_IDLE;
      endcase
    end
  end

  // Request capture, held for the whole cycle
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      op_q    <= apbi_pkg::OP_READ;
      addr_q  <= '0;
      wdata_q <= '0;
      word_q  <= 1'b0;
      space_q <= '0;
      lvl_q   <= '0;
    end
    else if (start)
    begin
      op_q    <= i_req_op;
      addr_q  <= i_req_addr;
      wdata_q <= i_req_wdata;
      word_q  <= i_req_word && !i_mode_8bit;
      space_q <= (i_req_op == apbi_pkg::OP_IACK) ? apbi_pkg::FC_IACK : i_req_space;
      lvl_q   <= i_iack_level;
    end
  end

  // Read data capture on acknowledge
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      rdata_q   <= '0;
      rd_push_q <= 1'b0;
      auto_q    <= 1'b0;
    end
    else
    begin
      rd_push_q <= 1'b0;
      if (cycle_end && op_q != apbi_pkg::OP_WRITE)
      begin
        rd_push_q <= 1'b1;
        rdata_q   <= i_data_lines;
        auto_q    <= (op_q == apbi_pkg::OP_IACK) && !i_auto_vector_request_n;
      end
    end
  end

  // ==========================================================================
  // Arbitration outputs
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_bus_grant_n <= 1'b1;
      o_ctrl_oe     <= 1'b0;
      o_address_oe  <= 1'b0;
    end
    else
    begin
      o_bus_grant_n <= !(bus_off && !i_bus_request_n);
      o_ctrl_oe     <= !bus_off;
      o_address_oe  <= !bus_off;
    end
  end

  // ==========================================================================
  // Bus cycle pin drive
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_address_lines       <= '0;
      o_address_strobe_n    <= 1'b1;
      o_upper_byte_strobe_n <= 1'b1;
      o_lower_byte_strobe_n <= 1'b1;
      o_read_write          <= 1'b1;
      o_data_lines          <= '0;
      o_data_oe             <= 1'b0;
      o_access_space_code   <= '0;
      o_iack_auto           <= 1'b0;
    end
    else
    begin
      o_iack_auto <= auto_q;
      if (state_q == apbi_pkg::ST_ADDR)
      begin
        o_address_lines     <= (op_q == apbi_pkg::OP_IACK) ? iack_addr(lvl_q) : addr_q;
        o_access_space_code <= space_q;
        o_read_write        <= (op_q != apbi_pkg::OP_WRITE);
        o_address_strobe_n  <= 1'b0;
        o_data_oe           <= (op_q == apbi_pkg::OP_WRITE);
        o_data_lines        <= (word_q || addr_q[0]) ? wdata_q : {wdata_q[7:0], wdata_q[7:0]};
        // Word: both halves; byte: even address upper, odd address lower
        o_upper_byte_strobe_n <= !(word_q || !addr_q[0] || op_q == apbi_pkg::OP_IACK);
        o_lower_byte_strobe_n <= !(word_q || addr_q[0] || op_q == apbi_pkg::OP_IACK);
      end
      else if (cycle_end)
      begin
        o_address_strobe_n    <= 1'b1;
        o_upper_byte_strobe_n <= 1'b1;
        o_lower_byte_strobe_n <= 1'b1;
      end
      else if (state_q == apbi_pkg::ST_DONE)
      begin
        o_data_oe    <= 1'b0;
        o_read_write <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Read data path; a stalled consumer extends the bus cycle
  apbi_buf #(.W(apbi_pkg::DATA_W)) u_buf
  (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_valid (rd_push_q),
    .o_ready (buf_ready),
    .i_data  (rdata_q),
    .o_valid (o_rd_valid),
    .i_ready (i_rd_ready),
    .o_data  (o_rd_data)
  );
endmodule // apbi_core

//--- testbench/apbi_core_sva.sv
// Pin-level assertions for the bus sequencer
`timescale 1ns/1ps
module apbi_core_chk
(
  input wire logic                          i_clk,
  input wire logic                          i_rst,
  input wire logic [apbi_pkg::ADDR_W-1:0]   o_address_lines,
  input wire logic                          o_address_oe,
  input wire logic                          o_address_strobe_n,
  input wire logic                          o_read_write,
  input wire logic                          o_upper_byte_strobe_n,
  input wire logic                          o_lower_byte_strobe_n,
  input wire logic [apbi_pkg::FC_W-1:0]     o_access_space_code,
  input wire logic                          o_ctrl_oe,
  input wire logic                          o_data_oe,
  input wire logic                          i_transfer_ack_n,
  input wire logic                          i_bus_request_n,
  input wire logic                          o_bus_grant_n,
  input wire logic                          i_mode_8bit,
  input wire logic [apbi_pkg::LVL_W-1:0]    i_interrupt_priority_inputs_n,
  input wire logic [apbi_pkg::LVL_W-1:0]    o_int_pending
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  // ==========================================================
  // Bus cycle
  a_addr_valid: assert property (!o_address_strobe_n |-> o_address_oe && o_ctrl_oe)
    else $error("strobe without driven address");
  a_strobe_any: assert property (!o_address_strobe_n |-> !(o_upper_byte_strobe_n && o_lower_byte_strobe_n))
    else $error("no byte strobe in cycle");
  a_byte_mode: assert property (!o_address_strobe_n && i_mode_8bit && o_access_space_code != 3'h7
    |-> o_upper_byte_strobe_n != o_lower_byte_strobe_n) else $error("word strobes in 8-bit mode");
  a_iack_ones: assert property (!o_address_strobe_n && o_access_space_code == 3'h7
    |-> &o_address_lines[23:4] && o_address_lines[0]) else $error("acknowledge address not ones");
  a_wait_hold: assert property (!o_address_strobe_n && i_transfer_ack_n
    |=> !o_address_strobe_n && $stable(o_address_lines) && $stable(o_read_write)) else $error("cycle not held");
  a_write_end: assert property (!o_address_strobe_n && !i_transfer_ack_n && !o_read_write
    |-> ##[1:2] o_address_strobe_n) else $error("write cycle did not end");
  a_write_oe: assert property (o_data_oe |-> !o_read_write)
    else $error("data driven in read cycle");
  // ==========================================================
  // Arbitration and interrupts
  a_grant_cause: assert property ($fell(o_bus_grant_n) |-> !$past(i_bus_request_n))
    else $error("grant without request");
  a_grant_quiet: assert property (!o_bus_grant_n |-> o_address_strobe_n && !o_ctrl_oe)
    else $error("bus driven while granted");
  a_nmi_pend: assert property (i_interrupt_priority_inputs_n == 3'h0 |-> o_int_pending == 3'h7)
    else $error("level seven not pending");
  cover property (!o_address_strobe_n && !i_transfer_ack_n && o_read_write);
  cover property ($fell(o_bus_grant_n));
  cover property (!o_address_strobe_n && o_access_space_code == 3'h7);
endmodule // apbi_core_chk

bind apbi_core apbi_core_chk chk_u (.*);

//--- testbench/apbi_mem_model.sv
// Memory partner answering the asynchronous bus
`timescale 1ns/1ps
module apbi_mem_model
(
  input  wire logic        i_clk,
  input  wire logic        i_address_strobe_n,
  input  wire logic        i_rw,
  input  wire logic        i_upper_byte_strobe_n,
  input  wire logic        i_lower_byte_strobe_n,
  input  wire logic [23:0] i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic [3:0]  i_wait,
  output logic [15:0]      o_rdata,
  output logic             o_ack_n
);
  logic [15:0] mem_q [8];
  logic [3:0]  cnt_q;
  always_ff @(posedge i_clk)
  begin
    if (i_address_strobe_n !== 1'b0)
    begin
      cnt_q   <= 4'h0;
      o_ack_n <= 1'b1;
      o_rdata <= ~o_rdata;
    end
    else if (cnt_q != i_wait)
      cnt_q <= cnt_q + 4'h1;
    else
    begin
      o_ack_n <= 1'b0;
      if (i_rw)
        o_rdata <= mem_q[i_addr[3:1]];
      if (!i_rw && !i_upper_byte_strobe_n)
        mem_q[i_addr[3:1]][15:8] <= i_wdata[15:8];
      if (!i_rw && !i_lower_byte_strobe_n)
        mem_q[i_addr[3:1]][7:0] <= i_wdata[7:0];
    end
  end
endmodule // apbi_mem_model

//--- testbench/testbench.sv
// Self-checking bench for the bus sequencer
`timescale 1ns/1ps
module testbench;
  logic i_clk = 1'b0, i_rst = 1'b1, i_req_valid = 1'b0, i_req_word = 1'b0, i_rd_ready = 1'b0, i_mode_8bit = 1'b0;
  logic i_auto_vector_request_n = 1'b1, i_bus_request_n = 1'b1, i_transfer_ack_n;
  apbi_pkg::apbi_op_t i_req_op = apbi_pkg::OP_READ;
  logic [23:0] i_req_addr = 24'h0, o_address_lines;
  logic [15:0] i_req_wdata = 16'h0, o_rd_data, o_data_lines, m_d;
  logic [3:0]  wait_c = 4'h0;
  logic [2:0]  i_req_space = 3'h5, i_iack_level = 3'h0, i_interrupt_priority_inputs_n = 3'h7, i_int_mask = 3'h0;
  logic [2:0]  o_access_space_code, o_int_pending;
  logic o_req_ready, o_rd_valid, o_iack_auto, o_address_oe, o_data_oe, o_address_strobe_n, o_read_write;
  logic o_upper_byte_strobe_n, o_lower_byte_strobe_n, o_ctrl_oe, o_bus_grant_n;
  wire [15:0] i_data_lines = o_data_oe ? o_data_lines : m_d;
  int n_fail = 0, num_checks = 0;
  logic clk_run = 1'b1;
  always #20 if (clk_run) i_clk = ~i_clk;
  apbi_core dut_u (.*);
  apbi_mem_model mem_u (.i_clk(i_clk), .i_address_strobe_n(o_address_strobe_n), .i_rw(o_read_write),
    .i_upper_byte_strobe_n(o_upper_byte_strobe_n), .i_lower_byte_strobe_n(o_lower_byte_strobe_n),
    .i_addr(o_address_lines), .i_wdata(i_data_lines), .i_wait(wait_c), .o_rdata(m_d), .o_ack_n(i_transfer_ack_n));
  // ==========================================================
  // Shared tasks
  task automatic close_out();
    if (n_fail == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic ck(input logic [23:0] got, input logic [23:0] exp, input string m);
    num_checks++;
    if (got !== exp)
    begin
      $display("MISMATCH %0t %s", $time, m);
      n_fail++;
    end
  endtask
  task automatic put(input apbi_pkg::apbi_op_t o, input logic [23:0] a, input logic [15:0] d, input logic w,
                     input logic [2:0] l);
    int k;
    logic iq;
    logic [1:0] sb;
    iq = (o == apbi_pkg::OP_IACK);
    sb = (iq | (w & !i_mode_8bit)) ? 2'h0 : {a[0], !a[0]};
    @(negedge i_clk);
    i_req_op = o;
    i_req_addr = a;
    i_req_wdata = d;
    i_req_word = w;
    i_iack_level = l;
    i_req_valid = 1'b1;
    for (k = 0; k < 80 && o_req_ready !== 1'b1; k++) @(negedge i_clk);
    @(negedge i_clk);
    i_req_valid = 1'b0;
    for (k = 0; k < 20 && o_address_strobe_n !== 1'b0; k++) @(negedge i_clk);
    ck(o_address_lines, iq ? {20'hfffff, l, 1'b1} : a, "address");
    ck({o_upper_byte_strobe_n, o_lower_byte_strobe_n}, sb, "strobes");
    ck(o_read_write, o != apbi_pkg::OP_WRITE, "direction");
    ck(o_access_space_code, iq ? 3'h7 : 3'h5, "space");
  endtask
  task automatic pop(input logic [15:0] e, input bit c);
    int k;
    for (k = 0; k < 80 && o_rd_valid !== 1'b1; k++) @(negedge i_clk);
    ck(o_rd_valid, 1'b1, "read valid");
    if (c) ck(o_rd_data, e, "read data");
    i_rd_ready = 1'b1;
    @(negedge i_clk);
    i_rd_ready = 1'b0;
    @(negedge i_clk);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_rw();
    put(apbi_pkg::OP_WRITE, 24'h000012, 16'h1234, 1'b1, 3'h0);
    wait_c = 4'h3;
    put(apbi_pkg::OP_WRITE, 24'h000024, 16'h00ab, 1'b0, 3'h0);
    put(apbi_pkg::OP_WRITE, 24'h000025, 16'h00cd, 1'b0, 3'h0);
    put(apbi_pkg::OP_READ, 24'h000012, 16'h0, 1'b1, 3'h0);
    pop(16'h1234, 1'b1);
    put(apbi_pkg::OP_READ, 24'h000024, 16'h0, 1'b1, 3'h0);
    pop(16'habcd, 1'b1);
    wait_c = 4'h0;
  endtask
  task automatic t_iack();
    int l;
    for (l = 1; l < 8; l++)
    begin
      i_auto_vector_request_n = (l != 7);
      put(apbi_pkg::OP_IACK, 24'h0, 16'h0, 1'b1, l[2:0]);
      pop(16'h0, 1'b0);
      ck(o_iack_auto, l == 7, "auto vector level");
    end
    ck(o_iack_auto, 1'b1, "auto vector");
    i_auto_vector_request_n = 1'b1;
  endtask
  task automatic t_stall();
    int k;
    for (k = 0; k < 3; k++) put(apbi_pkg::OP_READ, 24'h000012, 16'h0, 1'b1, 3'h0);
    repeat (12) @(negedge i_clk);
    ck(o_address_strobe_n, 1'b0, "held while full");
    for (k = 0; k < 3; k++) pop(16'h1234, 1'b1);
  endtask
  task automatic t_grant();
    int k;
    put(apbi_pkg::OP_READ, 24'h000012, 16'h0, 1'b1, 3'h0);
    i_bus_request_n = 1'b0;
    for (k = 0; k < 20 && o_bus_grant_n !== 1'b0; k++) @(negedge i_clk);
    ck({o_bus_grant_n, o_ctrl_oe, o_address_oe, o_req_ready}, 4'h0, "grant");
    i_bus_request_n = 1'b1;
    for (k = 0; k < 20 && o_bus_grant_n !== 1'b1; k++) @(negedge i_clk);
    ck(o_bus_grant_n, 1'b1, "release");
    pop(16'h1234, 1'b1);
  endtask
  task automatic t_irq();
    int k;
    logic [2:0] lv[4] = '{3'h3, 3'h3, 3'h7, 3'h1};
    logic [2:0] mk[4] = '{3'h2, 3'h3, 3'h7, 3'h0};
    logic [2:0] ex[4] = '{3'h3, 3'h0, 3'h7, 3'h1};
    for (k = 0; k < 4; k++)
    begin
      @(negedge i_clk);
      i_interrupt_priority_inputs_n = ~lv[k];
      i_int_mask = mk[k];
      #1;
      ck(o_int_pending, ex[k], "pending level");
    end
  endtask
  task automatic t_mode8();
    @(negedge i_clk);
    i_rst = 1'b1;
    i_mode_8bit = 1'b1;
    repeat (4) @(negedge i_clk);
    i_rst = 1'b0;
    ck({o_address_strobe_n, o_read_write, o_bus_grant_n, o_rd_valid}, 4'he, "reset idle");
    put(apbi_pkg::OP_WRITE, 24'h000033, 16'h005a, 1'b1, 3'h0);
    put(apbi_pkg::OP_WRITE, 24'h000032, 16'h005a, 1'b1, 3'h0);
    put(apbi_pkg::OP_READ, 24'h000032, 16'h0, 1'b1, 3'h0);
    pop(16'h5a5a, 1'b1);
  endtask
  task automatic t_sleep();
    put(apbi_pkg::OP_WRITE, 24'h000014, 16'hbeef, 1'b1, 3'h0);
    clk_run = 1'b0;
    #2010;
    ck(o_address_strobe_n, 1'b0, "held while clock stopped");
    clk_run = 1'b1;
    put(apbi_pkg::OP_READ, 24'h000014, 16'h0, 1'b1, 3'h0);
    pop(16'hbeef, 1'b1);
  endtask
  initial
  begin
    repeat (4) @(negedge i_clk);
    i_rst = 1'b0;
    t_rw();
    t_iack();
    t_stall();
    t_grant();
    t_sleep();
    t_irq();
    t_mode8();
    repeat (10) @(negedge i_clk);
    close_out();
  end
  initial
  begin
    #400000;
    n_fail++;
    close_out();
  end
endmodule // testbench
